// file: logic/sdpc_byte_lane.sv
module sdpc_byte_lane (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reading,
  input wire logic writing,
  input wire logic lane_mask,
  input wire logic [7:0] read_byte,
  input wire logic [7:0] pin_byte,
  output logic [7:0] out_byte,
  output logic out_enable,
  output logic [7:0] write_byte,
  output logic write_enable
);
  // One byte of the data pins: drivers and write strobe are both gated by the lane mask.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_byte <= 8'h00;
      out_enable <= 1'b0;
      write_byte <= 8'h00;
      write_enable <= 1'b0;
    end else begin
      out_byte <= read_byte;
      out_enable <= reading && !lane_mask;
      write_byte <= pin_byte;
      write_enable <= writing && !lane_mask;
    end
  end
endmodule : sdpc_byte_lane

// file: logic/sdpc_pkg.sv
// What this block does
// - The two bank-select pins pick one of four banks, code zero naming the first and the rest in binary order.
// - A row-open command latches all twelve address pins as the row address of the selected bank.
// - A read or write takes its column from address pins 0 to 7 and reads address pin 10 as the auto-precharge flag.
// - A precharge samples address pin 10: high closes every bank, low closes only the selected bank.
// - A mode register set takes its operation code from the address pins.
// - Every command is ignored when the command-select pin is sampled high.
// - The command-select pin is one bit of the command code together with the three strobes.
// - The strobes are latched on the rising clock edge and commands are decoded only from the latched values.
// - Select low, row strobe low, column and write strobes high opens the selected bank.
// - Select low, row strobe low, column strobe high, write strobe low is a precharge that returns banks to idle.
// - Select low, row strobe high, column strobe low starts a column access chosen by the write strobe.
// - In a column access a high write strobe means read and a low one means write.
// - Each byte mask turns off its byte's output drivers on reads and blocks its byte from being written on writes.
// - Read and write data move on the sixteen data pins at rising clock edges and both directions can be masked.
package sdpc_pkg;
  localparam int addr_width = 12;
  localparam int col_width = 8;
  localparam int data_width = 16;
  localparam int bank_count = 4;
  localparam int autoprecharge_bit = 10;
  localparam int lower_byte_lsb = 0;
  localparam int upper_byte_lsb = 8;
  localparam logic [11:0] row_reset = 12'h000;
  localparam logic [11:0] mode_reset = 12'h000;
  localparam logic [15:0] data_reset = 16'h0000;
  // Burst length used by the data path after a column access, in clock cycles.
  localparam int burst_cycles = 4;
  // Command code is {select, row strobe, column strobe, write strobe}, all active low.
  typedef enum logic [3:0] {
    sdpc_cmd_row_open = 4'b0011,
    sdpc_cmd_precharge = 4'b0010,
    sdpc_cmd_read = 4'b0101,
    sdpc_cmd_write = 4'b0100,
    sdpc_cmd_mode_set = 4'b0000,
    sdpc_cmd_refresh = 4'b0001,
    sdpc_cmd_burst_stop = 4'b0110,
    sdpc_cmd_nop = 4'b0111
  } sdpc_cmd_type;
  typedef enum logic [1:0] {
    sdpc_burst_idle = 2'b00,
    sdpc_burst_read = 2'b01,
    sdpc_burst_write = 2'b10
  } sdpc_burst_type;
endpackage : sdpc_pkg

// file: logic/sdpc_sync.sv
module sdpc_sync #(
  parameter int width = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [width-1:0] async_in,
  input wire logic [width-1:0] reset_value,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage_one;

  // Two flip-flops bring pin levels into the clock domain; the first stage feeds only the second.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage_one <= reset_value;
      sync_out <= reset_value;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule : sdpc_sync

// file: logic/sdpc_top.sv
module sdpc_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic bank_sel_lo,
  input wire logic bank_sel_hi,
  input wire logic [11:0] addr_pins,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  input wire logic [15:0] data_pins_in,
  output logic [15:0] data_pins_out,
  output logic [15:0] data_pins_oe,
  input wire logic [15:0] array_read_data,
  output logic [15:0] array_write_data,
  output logic [1:0] array_write_byte_en,
  output logic [1:0] access_bank,
  output logic [7:0] access_col,
  output logic access_autoprecharge,
  output logic [3:0] bank_active,
  output logic [47:0] bank_rows,
  output logic [11:0] mode_opcode,
  output logic mode_loaded,
  output logic read_burst,
  output logic write_burst
);
  // Synchronised pin levels.
  logic cs_n_s;
  logic ras_n_s;
  logic cas_n_s;
  logic we_n_s;
  logic [1:0] bank_s;
  logic [11:0] addr_s;
  logic [1:0] mask_s;
  logic [15:0] data_s;
  // Decoded command and state.
  sdpc_pkg::sdpc_cmd_type cmd;
  logic cmd_valid;
  sdpc_pkg::sdpc_burst_type burst;
  logic [2:0] burst_left;
  logic [1:0] lane_out_en;
  logic [1:0] lane_wr_en;
  logic [7:0] lane_out [2];
  logic [7:0] lane_wr [2];

  // The command and strobe pins pass two flip-flops; commands decode only from these.
  sdpc_sync #(.width(4)) u_cmd_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({cmd_select_n, row_strobe_n, col_strobe_n, write_strobe_n}),
    .reset_value(4'hf),
    .sync_out({cs_n_s, ras_n_s, cas_n_s, we_n_s})
  );

  // Bank, address, mask and data pins pass the same two stages so they stay aligned with the command.
  sdpc_sync #(.width(32)) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({bank_sel_hi, bank_sel_lo, addr_pins, upper_byte_mask, lower_byte_mask, data_pins_in}),
    .reset_value(32'h0000_0003),
    .sync_out({bank_s, addr_s, mask_s, data_s})
  );

  // Select is part of the code; with select high nothing decodes.
  assign cmd = sdpc_pkg::sdpc_cmd_type'({cs_n_s, ras_n_s, cas_n_s, we_n_s});
  assign cmd_valid = !cs_n_s;

  // Bank open state and row latches, one entry per bank.
  for (genvar b = 0; b < sdpc_pkg::bank_count; b++) begin : g_bank
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        bank_active[b] <= 1'b0;
        bank_rows[b*12 +: 12] <= sdpc_pkg::row_reset;
      end else if (cmd_valid && cmd == sdpc_pkg::sdpc_cmd_row_open && bank_s == 2'(b)) begin
        bank_active[b] <= 1'b1;
        bank_rows[b*12 +: 12] <= addr_s;
      end else if (cmd_valid && cmd == sdpc_pkg::sdpc_cmd_precharge) begin
        if (addr_s[sdpc_pkg::autoprecharge_bit] || bank_s == 2'(b)) begin
          bank_active[b] <= 1'b0;
        end
      end else if (burst != sdpc_pkg::sdpc_burst_idle && burst_left == 3'd1 && access_autoprecharge
                   && access_bank == 2'(b)) begin
        // Auto-precharge closes the bank when its burst ends.
        bank_active[b] <= 1'b0;
      end
    end
  end

  // Column access captures bank, column and the auto-precharge flag.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      access_bank <= 2'b00;
      access_col <= 8'h00;
      access_autoprecharge <= 1'b0;
    end else if (cmd_valid && (cmd == sdpc_pkg::sdpc_cmd_read || cmd == sdpc_pkg::sdpc_cmd_write)) begin
      access_bank <= bank_s;
      access_col <= addr_s[sdpc_pkg::col_width-1:0];
      access_autoprecharge <= addr_s[sdpc_pkg::autoprecharge_bit];
    end
  end

  // Mode register set takes the op-code from the address pins.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_opcode <= sdpc_pkg::mode_reset;
      mode_loaded <= 1'b0;
    end else if (cmd_valid && cmd == sdpc_pkg::sdpc_cmd_mode_set) begin
      mode_opcode <= addr_s;
      mode_loaded <= 1'b1;
    end
  end

  // Burst tracker: the write strobe picks read or write; a new access or stop cuts the burst.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      burst <= sdpc_pkg::sdpc_burst_idle;
      burst_left <= 3'd0;
    end else if (cmd_valid && cmd == sdpc_pkg::sdpc_cmd_read) begin
      burst <= sdpc_pkg::sdpc_burst_read;
      burst_left <= 3'(sdpc_pkg::burst_cycles);
    end else if (cmd_valid && cmd == sdpc_pkg::sdpc_cmd_write) begin
      burst <= sdpc_pkg::sdpc_burst_write;
      burst_left <= 3'(sdpc_pkg::burst_cycles);
    end else if (cmd_valid && (cmd == sdpc_pkg::sdpc_cmd_burst_stop || cmd == sdpc_pkg::sdpc_cmd_precharge)) begin
      burst <= sdpc_pkg::sdpc_burst_idle;
      burst_left <= 3'd0;
    end else if (burst_left > 3'd1) begin
      burst_left <= burst_left - 3'd1;
    end else begin
      burst <= sdpc_pkg::sdpc_burst_idle;
      burst_left <= 3'd0;
    end
  end

  // Registered burst flags for the outside.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      read_burst <= 1'b0;
      write_burst <= 1'b0;
    end else begin
      read_burst <= (burst == sdpc_pkg::sdpc_burst_read);
      write_burst <= (burst == sdpc_pkg::sdpc_burst_write);
    end
  end

  // One lane per byte; lane 0 takes the lower mask, lane 1 the upper.
  for (genvar l = 0; l < 2; l++) begin : g_lane
    sdpc_byte_lane u_lane (
      .clock(clock),
      .rst_n(rst_n),
      .reading(burst == sdpc_pkg::sdpc_burst_read),
      .writing(burst == sdpc_pkg::sdpc_burst_write),
      .lane_mask(mask_s[l]),
      .read_byte(array_read_data[l*8 +: 8]),
      .pin_byte(data_s[l*8 +: 8]),
      .out_byte(lane_out[l]),
      .out_enable(lane_out_en[l]),
      .write_byte(lane_wr[l]),
      .write_enable(lane_wr_en[l])
    );
  end

  // Pin outputs: byte enables fan out to every bit of the lane.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_pins_out <= sdpc_pkg::data_reset;
      data_pins_oe <= 16'h0000;
      array_write_data <= sdpc_pkg::data_reset;
      array_write_byte_en <= 2'b00;
    end else begin
      data_pins_out <= {lane_out[1], lane_out[0]};
      data_pins_oe <= {{8{lane_out_en[1]}}, {8{lane_out_en[0]}}};
      array_write_data <= {lane_wr[1], lane_wr[0]};
      array_write_byte_en <= lane_wr_en; // Enables leave in the same cycle as the data they guard.
    end
  end
endmodule : sdpc_top

// file: verification/sdpc_ctrl_model.sv
module sdpc_ctrl_model (
  input wire logic clock,
  output logic cmd_select_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_strobe_n,
  output logic bank_sel_lo,
  output logic bank_sel_hi,
  output logic [11:0] addr_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // The controller starts deselected.
  initial begin
    {cmd_select_n, row_strobe_n, col_strobe_n, write_strobe_n} = 4'hf;
    {bank_sel_hi, bank_sel_lo} = 2'h0;
    addr_pins = 12'h000;
  end
  // Drives one command for a cycle, then deselects and scrambles the stale address.
  task automatic issue(input logic [3:0] cmd, input logic [1:0] bank, input logic [11:0] addr);
    @(negedge clock);
    {cmd_select_n, row_strobe_n, col_strobe_n, write_strobe_n} = cmd;
    {bank_sel_hi, bank_sel_lo} = bank;
    addr_pins = addr;
    @(negedge clock);
    {cmd_select_n, row_strobe_n, col_strobe_n, write_strobe_n} = 4'hf;
    addr_pins = ~addr;
  endtask : issue
endmodule : sdpc_ctrl_model

// file: verification/sdpc_top_assertions.sv
module sdpc_top_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic bank_sel_lo,
  input wire logic bank_sel_hi,
  input wire logic [11:0] addr_pins,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  input wire logic [15:0] data_pins_oe,
  input wire logic [1:0] array_write_byte_en,
  input wire logic [3:0] bank_active,
  input wire logic [47:0] bank_rows,
  input wire logic [11:0] mode_opcode,
  input wire logic mode_loaded,
  input wire logic read_burst,
  input wire logic write_burst
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // The pin command code and bank code as the decoder sees them.
  wire logic [3:0] cmd = {cmd_select_n, row_strobe_n, col_strobe_n, write_strobe_n};
  wire logic [1:0] bank = {bank_sel_hi, bank_sel_lo};
  a_row_open_bank: assert property (cmd == sdpc_pkg::sdpc_cmd_row_open ##1 cmd_select_n |-> ##2
    bank_active[$past(bank, 3)]) else $error("row open left its bank idle");
  a_row_addr_latch: assert property (cmd == sdpc_pkg::sdpc_cmd_row_open ##1 cmd_select_n |-> ##2
    bank_rows[$past(bank, 3) * 12 +: 12] == $past(addr_pins, 3)) else $error("row address not latched");
  a_precharge_all: assert property (cmd == sdpc_pkg::sdpc_cmd_precharge && addr_pins[10] ##1 cmd_select_n
    |-> ##2 bank_active == 4'h0) else $error("precharge all left a bank open");
  a_mode_opcode: assert property (cmd == sdpc_pkg::sdpc_cmd_mode_set ##1 cmd_select_n |-> ##2
    mode_loaded && mode_opcode == $past(addr_pins, 3)) else $error("mode opcode not taken");
  a_deselect_ignored: assert property (cmd_select_n |-> ##3 $stable(mode_opcode) && $stable(mode_loaded))
    else $error("deselected cycle changed the mode");
  a_read_burst: assert property (cmd == sdpc_pkg::sdpc_cmd_read ##1 cmd_select_n |-> ##3
    read_burst && !write_burst) else $error("read did not start a read burst");
  a_write_burst: assert property (cmd == sdpc_pkg::sdpc_cmd_write ##1 cmd_select_n |-> ##3
    write_burst && !read_burst) else $error("write did not start a write burst");
  a_upper_lane_mask: assert property (upper_byte_mask [*6] |->
    data_pins_oe[15:8] == 8'h00 && !array_write_byte_en[1]) else $error("upper lane active while masked");
  // Main scenarios worth seeing at least once.
  c_row_open: cover property (cmd == sdpc_pkg::sdpc_cmd_row_open);
  c_read_burst: cover property (read_burst);
  c_write_burst: cover property (write_burst);
endmodule : sdpc_top_assertions

bind sdpc_top sdpc_top_assertions u_sdpc_top_assertions (.clock, .rst_n, .cmd_select_n, .row_strobe_n,
  .col_strobe_n, .write_strobe_n, .bank_sel_lo, .bank_sel_hi, .addr_pins, .lower_byte_mask, .upper_byte_mask,
  .data_pins_oe, .array_write_byte_en, .bank_active, .bank_rows, .mode_opcode, .mode_loaded, .read_burst,
  .write_burst);

// file: verification/test_sdpc_top.sv
module test_sdpc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, cmd_select_n, row_strobe_n, col_strobe_n, write_strobe_n, bank_sel_lo, bank_sel_hi;
  logic lower_byte_mask, upper_byte_mask, mode_loaded, read_burst, write_burst, access_autoprecharge;
  logic [1:0] array_write_byte_en, access_bank;
  logic [7:0] access_col;
  logic [3:0] bank_active;
  logic [11:0] addr_pins, mode_opcode;
  logic [15:0] data_pins_out, data_pins_oe, array_write_data, data_pins_in;
  logic [47:0] bank_rows;
  int fails = 0, n_tests = 0, cycles = 0;
  localparam logic [15:0] rd_word = 16'ha5c3;
  localparam logic [15:0] wr_word = 16'h3c96;
  // Each data pin shows the device while it drives and the controller otherwise.
  assign data_pins_in = (data_pins_oe & data_pins_out) | (~data_pins_oe & wr_word);
  sdpc_ctrl_model u_sdpc_ctrl_model (.clock, .cmd_select_n, .row_strobe_n, .col_strobe_n, .write_strobe_n,
    .bank_sel_lo, .bank_sel_hi, .addr_pins);
  sdpc_top u_sdpc_top (.clock, .rst_n, .cmd_select_n, .row_strobe_n, .col_strobe_n, .write_strobe_n,
    .bank_sel_lo, .bank_sel_hi, .addr_pins, .lower_byte_mask, .upper_byte_mask, .data_pins_in, .data_pins_out,
    .data_pins_oe, .array_read_data(rd_word), .array_write_data, .array_write_byte_en, .access_bank, .access_col,
    .access_autoprecharge, .bank_active, .bank_rows, .mode_opcode, .mode_loaded, .read_burst, .write_burst);
  // The clock runs at 40 MHz.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // A hang is cut short after a fixed number of cycles.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic skip(input int n);
    repeat (n) @(negedge clock);
  endtask : skip
  // Opens all four banks back to back, each with its own row.
  task automatic open_all_banks();
    logic [47:0] rows;
    for (int b = 0; b < 4; b++) begin
      rows[b * 12 +: 12] = 12'hfff - 12'(b * 12'h555);
      u_sdpc_ctrl_model.issue(sdpc_pkg::sdpc_cmd_row_open, b[1:0], rows[b * 12 +: 12]);
    end
    skip(2);
    check(48'(bank_active), 48'hf);
    check(bank_rows, rows);
  endtask : open_all_banks
  // Loads a mode, then offers a mode set and a precharge all while deselected.
  task automatic mode_then_deselect();
    u_sdpc_ctrl_model.issue(sdpc_pkg::sdpc_cmd_mode_set, 2'h0, 12'h5a3);
    skip(2);
    check(48'({mode_loaded, mode_opcode}), 48'h15a3);
    u_sdpc_ctrl_model.issue(4'b1000, 2'h0, 12'h0ff);
    u_sdpc_ctrl_model.issue(4'b1010, 2'h0, 12'h400);
    skip(2);
    check(48'({bank_active, mode_opcode}), 48'hf5a3);
  endtask : mode_then_deselect
  // Closes one bank with every other address bit high, then all banks.
  task automatic precharge_cases();
    u_sdpc_ctrl_model.issue(sdpc_pkg::sdpc_cmd_precharge, 2'h1, 12'hbff);
    skip(2);
    check(48'(bank_active), 48'hd);
    u_sdpc_ctrl_model.issue(sdpc_pkg::sdpc_cmd_precharge, 2'h2, 12'h400);
    skip(2);
    check(48'(bank_active), 48'h0);
  endtask : precharge_cases
  // Runs a column access with one byte lane masked and judges fields, burst and lanes.
  task automatic column_access(input logic wr, input logic [11:0] addr, input logic up, input logic lo);
    logic [15:0] lanes;
    lanes = {{8{~up}}, {8{~lo}}};
    {upper_byte_mask, lower_byte_mask} = {up, lo};
    u_sdpc_ctrl_model.issue(sdpc_pkg::sdpc_cmd_row_open, 2'h2, 12'h123);
    u_sdpc_ctrl_model.issue(wr ? sdpc_pkg::sdpc_cmd_write : sdpc_pkg::sdpc_cmd_read, 2'h2, addr);
    skip(2);
    check(48'({access_bank, access_col, access_autoprecharge}), 48'({2'h2, addr[7:0], addr[10]}));
    skip(1);
    check(48'({read_burst, write_burst}), 48'({~wr, wr}));
    skip(wr ? 2 : 3);
    if (wr) begin
      check(48'({array_write_byte_en, array_write_data}), 48'({~up, ~lo, wr_word}));
    end else begin
      check(48'({data_pins_oe, data_pins_out & data_pins_oe}), 48'({lanes, rd_word & lanes}));
    end
    skip(4);
    // Auto-precharge closes bank 2 when its burst ends; without the flag the bank stays open.
    check(48'(bank_active), addr[10] ? 48'h0 : 48'h4);
  endtask : column_access
  // Reset, then every scenario in turn.
  initial begin
    {rst_n, lower_byte_mask, upper_byte_mask} = 3'h0;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    check(48'({bank_active, mode_loaded, read_burst, write_burst, data_pins_oe}), 48'h0);
    open_all_banks();
    mode_then_deselect();
    precharge_cases();
    column_access(1'b0, 12'hbc7, 1'b1, 1'b0);
    column_access(1'b1, 12'h43c, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule : test_sdpc_top
